// *** design/ucp_cell_out.sv ***
// Purpose: Outgoing half of a dual-role cell bus port, ATM-end or PHY-end
// Assumes: 100 MHz i_clock; link clock either made here or sampled from the pin
// Notes: Software pushes cells word by word; 8-bit mode packs two bytes per word
//
// Summary of operation
// [R1] Link clock: internal half-rate or external input
// [R2] PHY mode uses five-bit address; ATM ignores
// [R3] Sixteen-bit bus, low byte only in 8-bit
// [R4] Level 2 floats data, parity, marker between cells
// [R5] Odd parity over active data bits
// [R6] Start marker high with first word
// [R7] ATM: PHY raises clav for whole cell
// [R8] PHY: ATM-end enable low, sampling follows
// [R9] ATM: enable output low while data valid
// [R10] PHY: clav output when full cell held
// [R11] Transmit role in ATM, receive in PHY
// [R12] Enables active low, rising link edge
// [R13] PHY answers only its own address
//
// The address map and register access over Wishbone were left to the implementer.
`timescale 1ns/1ps
`include "ucp_cfg.svh"
module ucp_cell_out (
	input wire logic i_clock,
	input wire logic i_rst,
	// Classic Wishbone slave
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [7:0] i_wb_adr,
	input wire logic [3:0] i_wb_sel,
	input wire logic [31:0] i_wb_dat,
	output logic o_wb_ack,
	output logic [31:0] o_wb_dat,
	// Link clock pin, three signals
	input wire logic i_cell_out_clock,
	output logic o_cell_out_clock,
	output logic o_cell_out_clock_oe,
	// Link pins
	input wire ucp_pkg::ucp_addr_t i_cell_out_phy_address,
	input wire logic i_cell_out_handshake_in,
	output ucp_pkg::ucp_word_t o_cell_out_bus,
	output logic o_cell_out_bus_oe,
	output logic o_cell_out_parity,
	output logic o_cell_out_parity_oe,
	output logic o_cell_out_start_marker,
	output logic o_cell_out_start_marker_oe,
	output logic o_cell_out_handshake_out
);
	import ucp_pkg::*;

	// Configuration and status registers
	logic [`UCP_CTRL_W-1:0] ctrl_ff;  // Mode, width, level, clock source, address, enable
	logic [15:0] cells_ff;  // Cells sent, wraps
	logic ack_ff;  // Bus answer
	logic [31:0] rdat_ff;  // Registered read data

	// Input synchronisers, two stages each
	logic clk_s1_ff, clk_s2_ff, clk_prev_ff;
	logic hs_s1_ff, hs_s2_ff;
	ucp_addr_t adr_s1_ff, adr_s2_ff;

	// Link clock generator
	logic clk_int_ff;  // Half-rate clock when made here
	logic clk_oe_ff;  // Pin driven only in internal mode

	// Sequencer
	ucp_state_t state_ff;
	logic [5:0] beat_ff;  // Beat within the cell
	logic [5:0] pops_ff;  // Fifo words already taken for this cell
	logic sel_ff;  // PHY mode: this port is selected
	ucp_word_t bus_ff;
	logic par_ff, soc_ff, oe_ff, hs_out_ff;

	// Fifo wires
	ucp_word_t head;
	logic fifo_in_ready, fifo_out_valid;
	logic [5:0] fifo_count;

	// Decoded configuration
	wire phy_mode = ctrl_ff[`UCP_CTRL_PHY];
	wire byte_mode = ctrl_ff[`UCP_CTRL_BYTE];
	wire level2 = ctrl_ff[`UCP_CTRL_LVL2];
	wire ext_clk = ctrl_ff[`UCP_CTRL_EXTCLK];
	wire enabled = ctrl_ff[`UCP_CTRL_EN];
	wire [4:0] own_addr = ctrl_ff[`UCP_CTRL_ADDR_HI:`UCP_CTRL_ADDR_LO];

	// Bus decode
	wire wb_req = i_wb_cyc & i_wb_stb & ~ack_ff;
	wire hit_ctrl = (i_wb_adr == `UCP_OFF_CTRL);
	wire hit_stat = (i_wb_adr == `UCP_OFF_STATUS);
	wire hit_data = (i_wb_adr == `UCP_OFF_DATA);
	wire data_wr = wb_req & i_wb_we & hit_data;
	// A data write waits for fifo room: this is the back-pressure to software
	wire wb_take = wb_req & (~data_wr | fifo_in_ready);
	wire push = data_wr & fifo_in_ready & (i_wb_sel[1:0] == 2'h3);
	wire ctrl_wr = wb_take & i_wb_we & hit_ctrl;

	// Link clock event: internal clock about to fall, or a seen external rise
	// Outputs change mid-period internally, giving the far end half a period of setup
	wire ext_rise = clk_s2_ff & ~clk_prev_ff;  // [R12]
	wire tick = ext_clk ? ext_rise : clk_int_ff;  // [R1]
	wire fire = tick & enabled;

	// Handshake input meaning depends on role
	wire far_clav = hs_s2_ff;  // [R7]
	wire far_enb_low = ~hs_s2_ff;  // [R8] [R12]
	wire addr_match = (adr_s2_ff == own_addr);  // [R2] [R13]

	// Words of the current cell still in the fifo are not free for the next one
	wire in_send = (state_ff == UCP_SEND);
	wire [5:0] words_left = in_send ? (`UCP_CELL_WORDS - pops_ff) : 6'h00;
	wire [5:0] avail = fifo_count - words_left;
	wire cell_ready = (avail >= `UCP_CELL_WORDS) & fifo_out_valid;

	// Start: ATM needs far clav, PHY needs selection and enable low
	wire start_atm = ~phy_mode & far_clav;  // [R7] [R11]
	wire start_phy = phy_mode & sel_ff & far_enb_low;  // [R8] [R13]
	wire start_ok = cell_ready & (start_atm | start_phy);
	// PHY mode pauses mid-cell while the ATM-end lifts its enable
	wire adv_ok = ~phy_mode | far_enb_low;  // [R8]
	wire drive = fire & (in_send ? adv_ok : start_ok);
	wire [5:0] beat = in_send ? beat_ff : 6'h00;
	wire [5:0] last_beat = byte_mode ? `UCP_LAST_BEAT8 : `UCP_LAST_BEAT16;
	wire is_last = (beat == last_beat);
	wire pop = drive & (~byte_mode | beat[0] | is_last);

	// Link word: full word, or alternating low then high byte
	wire [7:0] byte_sel = beat[0] ? head[15:8] : head[7:0];
	wire [15:0] nxt_bus = byte_mode ? {8'h00, byte_sel} : head;  // [R3]
	wire nxt_par = byte_mode ? ~(^byte_sel) : ~(^head);  // [R5]
	// Between cells level 1 keeps driving, level 2 floats
	wire idle_oe = ~level2;  // [R4]
	wire clav_out = cell_ready & addr_match;  // [R10] [R13]

	// Status word
	wire [31:0] stat_word = {cells_ff, 8'h00, cell_ready, in_send, fifo_count};
	wire [31:0] ctrl_word = {22'h000000, ctrl_ff};
	wire [31:0] nxt_rdat = hit_ctrl ? ctrl_word : (hit_stat ? stat_word : 32'h00000000);

	// Pin synchronisers; first stages feed only second stages
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			clk_s1_ff <= 1'b0;
			clk_s2_ff <= 1'b0;
			clk_prev_ff <= 1'b0;
			hs_s1_ff <= 1'b0;
			hs_s2_ff <= 1'b0;
			adr_s1_ff <= '0;
			adr_s2_ff <= '0;
		end else begin
			clk_s1_ff <= i_cell_out_clock;
			clk_s2_ff <= clk_s1_ff;
			clk_prev_ff <= clk_s2_ff;
			hs_s1_ff <= i_cell_out_handshake_in;
			hs_s2_ff <= hs_s1_ff;
			adr_s1_ff <= i_cell_out_phy_address;
			adr_s2_ff <= adr_s1_ff;
		end
	end

	// Internal link clock: toggles every cycle, i.e. half the system clock
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			clk_int_ff <= 1'b0;
			clk_oe_ff <= 1'b0;
		end else begin
			clk_int_ff <= ~ext_clk & ~clk_int_ff;  // [R1]
			clk_oe_ff <= ~ext_clk;  // [R1]
		end
	end

	// Wishbone answer: one cycle after the request is taken, dropped the cycle after
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			ack_ff <= 1'b0;
			rdat_ff <= 32'h00000000;
		end else begin
			ack_ff <= wb_take;
			if (wb_take) rdat_ff <= nxt_rdat;
		end
	end

	// Control register, byte lanes 0 and 1
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			ctrl_ff <= `UCP_CTRL_RST;
		end else if (ctrl_wr) begin
			if (i_wb_sel[0]) ctrl_ff[7:0] <= i_wb_dat[7:0];
			if (i_wb_sel[1]) ctrl_ff[`UCP_CTRL_W-1:8] <= i_wb_dat[`UCP_CTRL_W-1:8];
		end
	end

	// PHY selection: address seen while the enable is high picks the next sender
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			sel_ff <= 1'b0;
		end else if (~phy_mode) begin
			sel_ff <= 1'b0;  // [R2]
		end else if (fire & ~far_enb_low & ~in_send) begin
			sel_ff <= addr_match;  // [R2] [R13]
		end
	end

	// Sequencer state, beat and pop counters
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			state_ff <= UCP_IDLE;
			beat_ff <= 6'h00;
			pops_ff <= 6'h00;
			cells_ff <= 16'h0000;
		end else if (drive) begin
			case (state_ff)
				UCP_IDLE: begin
					state_ff <= UCP_SEND;
					beat_ff <= 6'h01;
					pops_ff <= 6'(pop);
				end
				UCP_SEND: begin
					if (is_last) begin
						// Cell done; a new one may start on the next link edge
						state_ff <= UCP_IDLE;
						beat_ff <= 6'h00;
						pops_ff <= 6'h00;
						cells_ff <= cells_ff + 16'h0001;
					end else begin
						beat_ff <= beat_ff + 6'h01;
						pops_ff <= pops_ff + 6'(pop);
					end
				end
				default: begin
					state_ff <= UCP_IDLE;
				end
			endcase
		end
	end

	// Link outputs, updated on the link event, or every cycle while the port is disabled
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			bus_ff <= 16'h0000;
			par_ff <= 1'b1;
			soc_ff <= 1'b0;
			oe_ff <= 1'b0;
			hs_out_ff <= 1'b1;
		end else if (drive) begin
			bus_ff <= nxt_bus;  // [R3] [R11]
			par_ff <= nxt_par;  // [R5]
			soc_ff <= (beat == 6'h00);  // [R6]
			oe_ff <= 1'b1;  // [R4]
			hs_out_ff <= phy_mode ? clav_out : 1'b0;  // [R9] [R10] [R12]
		end else if (fire & ~in_send) begin
			// Idle between cells: marker off, enable high or clav answer
			bus_ff <= 16'h0000;
			par_ff <= 1'b1;
			soc_ff <= 1'b0;
			oe_ff <= idle_oe;  // [R4]
			hs_out_ff <= phy_mode ? clav_out : 1'b1;  // [R9] [R10]
		end else if (fire) begin
			// Paused mid-cell: data held, clav still answers polls
			hs_out_ff <= clav_out;  // [R10]
		end else if (~enabled) begin
			oe_ff <= 1'b0;
			soc_ff <= 1'b0;
			hs_out_ff <= ~phy_mode;
		end
	end

	// Cell fifo, filled by software, drained by the sequencer
	ucp_fifo #(
		.WIDTH(16),
		.DEPTH(32)
	) u_fifo (
		.i_clock(i_clock),
		.i_rst(i_rst),
		.i_valid(push),
		.o_ready(fifo_in_ready),
		.i_data(i_wb_dat[15:0]),
		.o_valid(fifo_out_valid),
		.i_ready(pop),
		.o_data(head),
		.o_count(fifo_count)
	);

	// Port outputs, each straight from a flip-flop
	assign o_wb_ack = ack_ff;
	assign o_wb_dat = rdat_ff;
	assign o_cell_out_clock = clk_int_ff;
	assign o_cell_out_clock_oe = clk_oe_ff;
	assign o_cell_out_bus = bus_ff;
	assign o_cell_out_bus_oe = oe_ff;
	assign o_cell_out_parity = par_ff;
	assign o_cell_out_parity_oe = oe_ff;
	assign o_cell_out_start_marker = soc_ff;
	assign o_cell_out_start_marker_oe = oe_ff;
	assign o_cell_out_handshake_out = hs_out_ff;
endmodule : ucp_cell_out

// *** shared/ucp_cfg.svh ***
// Purpose: Offsets, field positions, reset values and counts of the cell output port
// Assumes: Byte addresses on a 32-bit classic Wishbone bus
// Notes: Definitions only
`ifndef UCP_CFG_SVH
`define UCP_CFG_SVH

// Register byte offsets
`define UCP_OFF_CTRL 8'h00
`define UCP_OFF_STATUS 8'h04
`define UCP_OFF_DATA 8'h08

// Control register fields
`define UCP_CTRL_PHY 0
`define UCP_CTRL_BYTE 1
`define UCP_CTRL_LVL2 2
`define UCP_CTRL_EXTCLK 3
`define UCP_CTRL_ADDR_LO 4
`define UCP_CTRL_ADDR_HI 8
`define UCP_CTRL_EN 9
`define UCP_CTRL_W 10
`define UCP_CTRL_RST 10'h000

// Status register fields
`define UCP_STAT_CNT_HI 5
`define UCP_STAT_BUSY 6
`define UCP_STAT_READY 7
`define UCP_STAT_CELLS_LO 16

// Cell geometry: fifo words per cell and index of the last link beat of a cell
`define UCP_CELL_WORDS 6'h1B
`define UCP_LAST_BEAT16 6'h1A
`define UCP_LAST_BEAT8 6'h34

`endif

// *** shared/ucp_pkg.sv ***
// Purpose: Types shared by the cell output port files
// Assumes: Constants live in ucp_cfg.svh
// Notes: Types only
package ucp_pkg;
	// One fifo word and one link word
	typedef logic [15:0] ucp_word_t;
	// Multi-PHY address on the link
	typedef logic [4:0] ucp_addr_t;
	// Transmit sequencer states
	typedef enum logic [0:0] {UCP_IDLE, UCP_SEND} ucp_state_t;
endpackage : ucp_pkg

// *** design/ucp_fifo.sv ***
// Purpose: Word FIFO between the register bus and the link sequencer
// Assumes: Single clock, asynchronous active-high reset
// Notes: Full and empty are exact; count is visible for cell accounting
`timescale 1ns/1ps
module ucp_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 32
) (
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic i_valid,
	output logic o_ready,
	input wire logic [WIDTH-1:0] i_data,
	output logic o_valid,
	input wire logic i_ready,
	output logic [WIDTH-1:0] o_data,
	output logic [$clog2(DEPTH):0] o_count
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];  // Storage array
	logic [AW-1:0] wr_ptr_ff;  // Next slot to write
	logic [AW-1:0] rd_ptr_ff;  // Oldest word
	logic [AW:0] count_ff;  // Words held
	wire do_push = i_valid & o_ready;
	wire do_pop = i_ready & o_valid;

	// Ready and valid follow the count directly
	assign o_ready = (count_ff != (AW+1)'(DEPTH));
	assign o_valid = (count_ff != '0);
	assign o_data = mem[rd_ptr_ff];
	assign o_count = count_ff;

	// Storage needs no reset; only written slots are ever read
	always_ff @(posedge i_clock) begin
		if (do_push) begin
			mem[wr_ptr_ff] <= i_data;
		end
	end

	// Pointers wrap at DEPTH, which is a power of two
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			count_ff <= '0;
		end else begin
			if (do_push) wr_ptr_ff <= wr_ptr_ff + 1'b1;
			if (do_pop) rd_ptr_ff <= rd_ptr_ff + 1'b1;
			count_ff <= count_ff + (AW+1)'(do_push) - (AW+1)'(do_pop);
		end
	end
endmodule : ucp_fifo

// *** testbench/ucp_cell_out_checker.sv ***
// Purpose: Link and clock assertions for the cell output port
// Assumes: Mode bits follow acked whole-word writes to the control register
// Notes: Mode is changed only while disabled or just after reset
`timescale 1ns/1ps
`include "ucp_cfg.svh"
module ucp_cell_out_checker (
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic i_wb_we,
	input wire logic [7:0] i_wb_adr,
	input wire logic [31:0] i_wb_dat,
	input wire logic o_wb_ack,
	input wire logic o_cell_out_clock,
	input wire logic o_cell_out_clock_oe,
	input wire ucp_pkg::ucp_word_t o_cell_out_bus,
	input wire logic o_cell_out_bus_oe,
	input wire logic o_cell_out_parity,
	input wire logic o_cell_out_parity_oe,
	input wire logic o_cell_out_start_marker,
	input wire logic o_cell_out_start_marker_oe,
	input wire logic o_cell_out_handshake_out
);
	import ucp_pkg::*;
	logic [9:0] ctrl_ff; // Shadow of the mode bits
	wire logic phy = ctrl_ff[`UCP_CTRL_PHY]; // PHY-end role
	wire logic lvl2 = ctrl_ff[`UCP_CTRL_LVL2]; // Float between cells
	wire logic byte_m = ctrl_ff[`UCP_CTRL_BYTE]; // Narrow bus
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_rst);
	// Shadow lags the design by a cycle, harmless while the port is idle
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			ctrl_ff <= `UCP_CTRL_RST;
		end else if (o_wb_ack && i_wb_we && i_wb_adr == `UCP_OFF_CTRL) begin
			ctrl_ff <= i_wb_dat[9:0];
		end
	end
	a_parity_odd: assert property (o_cell_out_bus_oe
		|-> ^{o_cell_out_bus, o_cell_out_parity}) else $error("parity not odd on driven bus");
	a_oe_tied: assert property (o_cell_out_parity_oe == o_cell_out_bus_oe
		&& o_cell_out_start_marker_oe == o_cell_out_bus_oe) else $error("enables differ");
	a_soc_enb: assert property (!phy && o_cell_out_start_marker
		|-> !o_cell_out_handshake_out) else $error("marker without enable");
	a_idle_float: assert property (!phy && lvl2 && o_cell_out_handshake_out
		|-> !o_cell_out_bus_oe) else $error("bus driven between cells");
	a_clk_half: assert property (o_cell_out_clock_oe && $past(o_cell_out_clock_oe)
		|-> o_cell_out_clock != $past(o_cell_out_clock)) else $error("clock not half rate");
	a_byte_high: assert property (byte_m && o_cell_out_bus_oe
		|-> o_cell_out_bus[15:8] == 8'h00) else $error("upper byte active in narrow mode");
	a_soc_short: assert property (!phy && $rose(o_cell_out_start_marker)
		|-> ##[1:10] !o_cell_out_start_marker) else $error("marker too long");
	a_enb_run: assert property (!phy && $fell(o_cell_out_handshake_out)
		|-> !o_cell_out_handshake_out [*8]) else $error("enable gap in cell");
	// Main scenarios reached
	c_atm: cover property (!phy && $fell(o_cell_out_handshake_out));
	c_phy: cover property (phy && o_cell_out_start_marker);
	c_byte: cover property (byte_m && o_cell_out_start_marker);
endmodule : ucp_cell_out_checker
bind ucp_cell_out ucp_cell_out_checker u_chk (.i_clock, .i_rst, .i_wb_we, .i_wb_adr, .i_wb_dat,
	.o_wb_ack, .o_cell_out_clock, .o_cell_out_clock_oe, .o_cell_out_bus, .o_cell_out_bus_oe,
	.o_cell_out_parity, .o_cell_out_parity_oe, .o_cell_out_start_marker,
	.o_cell_out_start_marker_oe, .o_cell_out_handshake_out);

// *** testbench/ucp_link_model.sv ***
// Purpose: Far end of the link, PHY in ATM mode or ATM-end in PHY mode
// Assumes: Bench says when the far end will take a cell
// Notes: Own clock runs free at 80 ns, used in external clock mode and during reset
`timescale 1ns/1ps
module ucp_link_model (
	input wire logic i_link_clock,
	input wire logic i_phy_mode,
	input wire logic i_accept,
	input wire ucp_pkg::ucp_addr_t i_poll,
	output logic o_ext_clock,
	output logic o_handshake,
	output ucp_pkg::ucp_addr_t o_address
);
	import ucp_pkg::*;
	// Free-running link clock, phase unrelated to the system clock
	// Handshake and address get their first value on a link edge during reset
	initial begin
		o_ext_clock = 1'b0;
		forever #40 o_ext_clock = ~o_ext_clock;
	end
	// Clav high only when a whole cell fits; enable is active low
	always @(posedge i_link_clock) begin
		o_handshake <= i_phy_mode ? ~i_accept : i_accept;
		o_address <= i_poll;
	end
endmodule : ucp_link_model

// *** testbench/testbench.sv ***
// Purpose: Self-checking bench of the cell output port
// Assumes: Cells of 27 words, loaded over classic Wishbone
// Notes: Each scenario starts from a fresh reset
`timescale 1ns/1ps
`include "ucp_cfg.svh"
module testbench;
	import ucp_pkg::*;
	logic i_clock = 1'b0, i_rst = 1'b1, cyc = 1'b0, we = 1'b0, phy_m = 1'b0, acc = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'hF;
	logic [31:0] dat = 32'h0, q;
	ucp_addr_t poll = 5'h00;
	wire logic ack, ext_clk, hs_in, clk_o, clk_oe, bus_oe, par, par_oe, soc, soc_oe, hs_out;
	wire logic [31:0] rdat;
	wire ucp_addr_t addr;
	wire ucp_word_t bus;
	wire logic link_clk = clk_oe ? clk_o : ext_clk; // Pin level from both drivers
	// Released pins have no pull, so they read back inverted: a float mid-cell is caught
	wire ucp_word_t pin_bus = bus_oe ? bus : ~bus;
	wire logic pin_par = par_oe ? par : ~par;
	wire logic pin_soc = soc_oe ? soc : ~soc;
	int n_errors = 0, cmp_count = 0, nb = 99, nbeats = 27;
	ucp_word_t got [0:63]; // Captured beats
	logic enb [0:63]; // Handshake seen with each beat
	initial forever #5 i_clock = ~i_clock;
	ucp_cell_out uut (.i_clock(i_clock), .i_rst(i_rst), .i_wb_cyc(cyc), .i_wb_stb(cyc),
		.i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(dat), .o_wb_ack(ack),
		.o_wb_dat(rdat), .i_cell_out_clock(link_clk), .o_cell_out_clock(clk_o),
		.o_cell_out_clock_oe(clk_oe), .i_cell_out_phy_address(addr),
		.i_cell_out_handshake_in(hs_in), .o_cell_out_bus(bus), .o_cell_out_bus_oe(bus_oe),
		.o_cell_out_parity(par), .o_cell_out_parity_oe(par_oe),
		.o_cell_out_start_marker(soc), .o_cell_out_start_marker_oe(soc_oe),
		.o_cell_out_handshake_out(hs_out));
	ucp_link_model far (.i_link_clock(link_clk), .i_phy_mode(phy_m), .i_accept(acc),
		.i_poll(poll), .o_ext_clock(ext_clk), .o_handshake(hs_in), .o_address(addr));
	// Far side samples on its rising edge; a marker starts a new capture
	always @(posedge link_clk) begin
		if (pin_soc === 1'b1 && bus_oe === 1'b1 && nb >= nbeats) begin
			nb = 0;
		end
		if (nb < nbeats) begin
			got[nb] = pin_bus;
			enb[nb] = hs_out;
			chk(^{pin_bus, pin_par}, 1);
			chk(pin_soc, nb == 0);
			nb = nb + 1;
		end
	end
	function automatic ucp_word_t wv(input int k);
		return {8'(k) ^ 8'hC3, 8'(k)};
	endfunction : wv
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : chk
	task automatic close_out();
		if (n_errors == 0 && cmp_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : close_out
	// One classic cycle; held until ack is sampled high
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		int n;
		n = 0;
		@(posedge i_clock);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		sel <= s;
		do begin
			@(posedge i_clock);
			n++;
		end while (ack !== 1'b1 && n < 3000);
		q = rdat;
		cyc <= 1'b0;
		if (n >= 3000) begin
			n_errors++;
			close_out();
		end
	endtask : wb
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		wb(1'b0, a, 32'h0, 4'hF);
		chk(q, exp);
	endtask : rd
	task automatic load(input int from, input int n);
		for (int k = from; k < from + n; k++) wb(1'b1, `UCP_OFF_DATA, {16'h0, wv(k)}, 4'hF);
	endtask : load
	task automatic wait_cell();
		int n;
		for (n = 0; n < 5000 && nb != nbeats; n++) @(posedge i_clock);
		if (n >= 5000) begin
			n_errors++;
			close_out();
		end
	endtask : wait_cell
	task automatic reset();
		@(posedge i_clock);
		i_rst <= 1'b1;
		repeat (6) @(posedge i_clock);
		i_rst <= 1'b0;
		nb = 99;
		repeat (2) @(posedge i_clock);
	endtask : reset
	// Idle levels, control reset value, unmapped place reads zero
	task automatic t_reset();
		reset();
		chk(hs_out, 1);
		chk(bus_oe, 0);
		chk(clk_oe, 1);
		wb(1'b1, 8'h40, 32'hFFFF_FFFF, 4'hF);
		rd(8'h40, 32'h0);
		rd(`UCP_OFF_CTRL, 32'h0);
	endtask : t_reset
	// Level 2, cell held back until clav, then 27 beats
	task automatic t_atm_l2();
		reset();
		wb(1'b1, `UCP_OFF_CTRL, 32'h204, 4'hF);
		load(0, 27);
		repeat (200) @(posedge i_clock);
		chk(hs_out, 1);
		chk(nb, 99);
		acc <= 1'b1;
		wait_cell();
		for (int i = 0; i < 27; i++) begin
			chk(got[i], wv(i));
			chk(enb[i], 0);
		end
		repeat (10) @(posedge i_clock);
		chk(bus_oe, 0);
		chk(hs_out, 1);
		rd(`UCP_OFF_STATUS, 32'h0001_0000);
		acc <= 1'b0;
	endtask : t_atm_l2
	// Narrow bus, external clock, level 1 keeps driving
	task automatic t_atm_b8();
		reset();
		nbeats = 53;
		acc <= 1'b1;
		wb(1'b1, `UCP_OFF_CTRL, 32'h20A, 4'hF);
		load(0, 27);
		wait_cell();
		for (int b = 0; b < 53; b++) chk(got[b], b % 2 ? wv(b / 2) >> 8 : wv(b / 2) & 16'hFF);
		chk(bus_oe, 1);
		chk(clk_oe, 0);
		acc <= 1'b0;
		nbeats = 27;
	endtask : t_atm_b8
	// PHY role: clav only for a whole cell and the own address
	task automatic t_phy();
		reset();
		phy_m <= 1'b1;
		poll <= 5'h03;
		wb(1'b1, `UCP_OFF_CTRL, 32'h251, 4'hF);
		load(0, 26);
		repeat (40) @(posedge i_clock);
		chk(hs_out, 0);
		load(26, 1);
		acc <= 1'b1;
		repeat (100) @(posedge i_clock);
		chk(hs_out, 0);
		chk(nb, 99);
		acc <= 1'b0;
		poll <= 5'h05;
		repeat (40) @(posedge i_clock);
		chk(hs_out, 1);
		acc <= 1'b1;
		wait_cell();
		for (int i = 0; i < 27; i++) chk(got[i], wv(i));
		repeat (10) @(posedge i_clock);
		chk(hs_out, 0);
		acc <= 1'b0;
		phy_m <= 1'b0;
	endtask : t_phy
	// Fill the buffer until a write stalls, then drain it empty
	task automatic t_fifo();
		reset();
		wb(1'b1, `UCP_OFF_CTRL, 32'h200, 4'hF);
		wb(1'b1, `UCP_OFF_DATA, 32'h1234, 4'hC);
		rd(`UCP_OFF_STATUS, 32'h0);
		load(0, 32);
		rd(`UCP_OFF_STATUS, 32'h0000_00A0);
		fork
			load(32, 1);
			begin
				repeat (50) @(posedge i_clock);
				chk(ack, 0);
				acc <= 1'b1;
			end
		join
		wait_cell();
		rd(`UCP_OFF_STATUS, 32'h0001_0006);
		nb = 99;
		load(33, 21);
		wait_cell();
		repeat (10) @(posedge i_clock);
		rd(`UCP_OFF_STATUS, 32'h0002_0000);
	endtask : t_fifo
	initial begin
		t_reset();
		t_atm_l2();
		t_atm_b8();
		t_phy();
		t_fifo();
		close_out();
	end
endmodule : testbench
